// >>> video_matrix_serial_control_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module video_matrix_serial_control_tb_top;
   logic       sys_clk;
   logic       reset;
   logic       scl;
   logic       sda_drv;
   wire        sda_line;
   logic [2:0] strap;
   logic       sda_out;
   logic       sda_oe;
   logic [7:0] route;
   logic [3:0] gain;
   logic [1:0] clamp;
   logic       aux0;
   logic       aux1;
   logic [3:0] drive;
   logic       pin_mode;
   logic [7:0] exp_route;
   logic [7:0] exp_gca;
   logic [7:0] exp_oe;
   int         num_errors = 0;
   int         checked = 0;
   int         cycles = 0;
   logic [7:0] bad_addr [4] = '{8'h98, 8'h9B, 8'h9A, 8'h9A};
   logic [7:0] bad_sub [4] = '{8'h00, 8'h00, 8'h04, 8'h03};

   // wired-and of master release and device pull-down
   assign sda_line = sda_drv & ~(sda_oe & ~sda_out);

   vms_master master_u (
      .i_sda_line (sda_line),
      .o_scl      (scl),
      .o_sda_drv  (sda_drv)
   );

   vms_top dut_u (
      .i_sys_clk         (sys_clk),
      .i_reset           (reset),
      .i_link_scl_clk    (scl),
      .i_scl_level       (scl),
      .i_sda_in          (sda_line),
      .i_strap_bit_low   (strap[0]),
      .i_strap_bit_mid   (strap[1]),
      .i_strap_bit_high  (strap[2]),
      .o_sda_out         (sda_out),
      .o_sda_oe          (sda_oe),
      .o_route           (route),
      .o_gain_sel        (gain),
      .o_clamp_off       (clamp),
      .o_aux_logic_out_0 (aux0),
      .o_aux_logic_out_1 (aux1),
      .o_drive_on        (drive),
      .o_pin_mode        (pin_mode)
   );

   initial begin
      sys_clk = 1'b0;
      forever #2 sys_clk = ~sys_clk;
   end

   // hang guard: the whole run needs well under this many cycles
   always @(posedge sys_clk) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         num_errors++;
         end_sim();
      end
   end

   task automatic end_sim();
      $display("checks %0d errors %0d", checked, num_errors);
      if (num_errors == 0 && checked > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask

   task automatic chk_val(input string name, input logic [7:0] exp, input logic [7:0] got);
      checked++;
      if (got !== exp) begin
         num_errors++;
         $display("[ERR] %s expected %h seen %h", name, exp, got);
      end
   endtask

   task automatic chk_ack(input string name, input logic exp, input logic got);
      checked++;
      if (got !== exp) begin
         num_errors++;
         $display("[ERR] %s expected %b seen %b", name, exp, got);
      end
   endtask

   // one byte on the wire and its acknowledge compared
   task automatic send(input logic [7:0] v, input logic exp_ack);
      logic ack;
      master_u.put_byte(v, ack);
      chk_ack("ack", exp_ack, ack);
   endtask

   // straps change only while reset is held
   task automatic do_reset(input logic [2:0] s);
      @(negedge sys_clk);
      reset = 1'b1;
      strap = s;
      repeat (8) @(negedge sys_clk);
      reset = 1'b0;
      repeat (20) @(negedge sys_clk);
   endtask

   // crossing plus output flop settle well inside 30 cycles
   task automatic check_outs(input string test, input logic exp_pin);
      repeat (30) @(negedge sys_clk);
      chk_val("route", exp_route, route);
      chk_val("gain", {4'h0, exp_gca[7:4]}, {4'h0, gain});
      chk_val("clamp", {6'h00, exp_gca[3:2]}, {6'h00, clamp});
      chk_val("aux", {6'h00, exp_gca[1:0]}, {6'h00, aux1, aux0});
      chk_val("drive", {4'h0, exp_oe[3:0]}, {4'h0, drive});
      chk_val("pin_mode", {7'h00, exp_pin}, {7'h00, pin_mode});
      $display("test %s done", test);
   endtask

   initial begin
      reset = 1'b1;
      strap = 3'h5;
      do_reset(3'h5);
      exp_route = 8'h00;
      exp_gca = 8'h00;
      exp_oe = 8'h00;
      check_outs("reset", 1'b0);
      // burst from select 01 runs through 02 and wraps to 00 then 01
      master_u.start();
      send(8'h9A, 1'b1);
      send(8'h01, 1'b1);
      send(8'h5A, 1'b1);
      send(8'h0F, 1'b1);
      send(8'hE4, 1'b1);
      send(8'hA3, 1'b1);
      master_u.stop();
      exp_route = 8'hE4;
      exp_gca = 8'hA3;
      exp_oe = 8'h0F;
      check_outs("burst_wrap", 1'b0);
      master_u.start();
      send(8'h9A, 1'b1);
      send(8'h00, 1'b1);
      send(8'h1B, 1'b1);
      send(8'h5A, 1'b1);
      master_u.stop();
      master_u.start();
      send(8'h9A, 1'b1);
      send(8'h02, 1'b1);
      send(8'hF5, 1'b1);
      master_u.stop();
      exp_route = 8'h1B;
      exp_gca = 8'h5A;
      exp_oe = 8'h05;
      check_outs("each_select", 1'b0);
      // wrong strap bits, read direction, bad selects: refused, nothing stored
      for (int k = 0; k < 4; k++) begin
         master_u.start();
         send(bad_addr[k], k >= 2);
         send(bad_sub[k], 1'b0);
         send(8'h55, 1'b0);
         master_u.stop();
      end
      check_outs("refusals", 1'b0);
      // a half byte cut off by stop leaves the register alone
      master_u.start();
      send(8'h9A, 1'b1);
      send(8'h00, 1'b1);
      for (int k = 0; k < 4; k++) begin
         master_u.put_bit(1'b0);
      end
      master_u.stop();
      check_outs("abort", 1'b0);
      // all straps high: pin control, idle lines high swap both pairs
      do_reset(3'h7);
      master_u.start();
      send(8'h9E, 1'b0);
      master_u.stop();
      exp_route = 8'h1B;
      exp_gca = 8'h00;
      exp_oe = 8'h0F;
      check_outs("pin_mode", 1'b1);
      // the other three line levels steer the routing as plain inputs
      master_u.lines(1'b1, 1'b0);
      exp_route = 8'h4E;
      check_outs("pin_data_low", 1'b1);
      master_u.lines(1'b0, 1'b0);
      exp_route = 8'hE4;
      check_outs("pin_both_low", 1'b1);
      master_u.lines(1'b0, 1'b1);
      exp_route = 8'hB1;
      check_outs("pin_clock_low", 1'b1);
      end_sim();
   end
endmodule
`default_nettype wire

// >>> vms_map.svh
`ifndef VMS_MAP_SVH
`define VMS_MAP_SVH
// Notes on behaviour
// - answer only address 1001 + strap bits + write bit zero
// - variable address bits follow the three straps, high strap to high bit
// - all straps high: not addressable, pin-controlled routing instead
// - acknowledge address, select byte and every accepted data byte
// - select byte has zero bits 7:2; values 00, 01, 02 pick registers
// - pointer steps by one after each data byte
// - after the third register the pointer wraps to the first
// - at power-up outputs are high impedance, logic outputs low
// - routing byte holds one two-bit source field per output
// - each output switched alone between active and high impedance
// - gain per output selectable between one and two
// - two bus-driven logic outputs for sound switching
// - field values 0 to 3 pick sources 0 to 3
// - gain bits 7:4 (zero gives two), clamp-off 3:2, logic outputs 1:0
// - enable bits 3:0 make outputs active, upper bits ignored
// - after reset: all routed to source 0, gain two, clamps on

// fixed upper nibble of the device address byte
`define VMS_ADDR_FIXED 4'h9
// register select values
`define VMS_OFS_ROUTE  2'h0
`define VMS_OFS_GCA    2'h1
`define VMS_OFS_OE     2'h2
// reset values
`define VMS_RST_ROUTE  8'h00
`define VMS_RST_GCA    8'h00
`define VMS_RST_OE     8'h00
// field positions in the gain/clamp/aux byte and the enable byte
`define VMS_GAIN_MSB   7
`define VMS_GAIN_LSB   4
`define VMS_CLAMP_MSB  3
`define VMS_CLAMP_LSB  2
`define VMS_AUX1_BIT   1
`define VMS_AUX0_BIT   0
`define VMS_EN_MSB     3
// pin-controlled mode: all outputs active
`define VMS_PIN_DRIVE  4'hF
// bit counter value of the acknowledge slot
`define VMS_ACK_SLOT   4'h8
`endif

// >>> vms_master.sv
`timescale 1ns/1ps
`default_nettype none
// serial bus master model; its clock stands high between frames
module vms_master (
   input  wire logic i_sda_line,
   output logic      o_scl,
   output logic      o_sda_drv
);
   initial begin
      o_scl = 1'b1;
      o_sda_drv = 1'b1;
   end

   // start: data falls while clock high; clock held low past the clear window
   task automatic start();
      #13.3;
      o_sda_drv = 1'b0;
      #80;
      o_scl = 1'b0;
      #40;
   endtask

   // data changes only while the clock is low, 160 ns per bit
   task automatic put_bit(input logic b);
      o_sda_drv = b;
      #40;
      o_scl = 1'b1;
      #80;
      o_scl = 1'b0;
      #40;
   endtask

   // msb first, then a ninth clock with data released to its pull-up level
   task automatic put_byte(input logic [7:0] v, output logic ack);
      for (int i = 7; i >= 0; i--) begin
         put_bit(v[i]);
      end
      o_sda_drv = 1'b1;
      #40;
      o_scl = 1'b1;
      ack = ~i_sda_line;
      #80;
      o_scl = 1'b0;
      #40;
   endtask

   // static levels on both lines; in pin mode they only steer the routing
   task automatic lines(input logic c, input logic d);
      o_scl = c;
      o_sda_drv = d;
   endtask

   // stop: data rises while clock high, clock then stands high
   task automatic stop();
      o_sda_drv = 1'b0;
      #40;
      o_scl = 1'b1;
      #80;
      o_sda_drv = 1'b1;
      #80;
   endtask
endmodule
`default_nettype wire

// >>> vms_pkg.sv
`default_nettype none
package vms_pkg;
   // receive phase of one frame on the link
   typedef enum logic [1:0] {
      PH_ADDR,
      PH_SUB,
      PH_DATA,
      PH_IGNORE
   } vms_phase_e;
   // register pointer
   typedef logic [1:0] vms_idx_t;
endpackage
`default_nettype wire

// >>> vms_sync.sv
`timescale 1ns/1ps
`default_nettype none
// three-flop pin synchroniser; the level moves once flops two and three agree
module vms_sync #(
   parameter int WIDTH = 5
) (
   input  wire logic             i_clk,
   input  wire logic             i_reset,
   input  wire logic [WIDTH-1:0] i_pin,
   output logic      [WIDTH-1:0] o_level
);
   logic [WIDTH-1:0] ff1_q;
   logic [WIDTH-1:0] ff2_q;
   logic [WIDTH-1:0] ff3_q;
   logic [WIDTH-1:0] lvl_q;

   // ff1 feeds ff2 only
   always_ff @(posedge i_clk or posedge i_reset) begin
      if (i_reset) begin
         ff1_q <= '0;
         ff2_q <= '0;
         ff3_q <= '0;
         lvl_q <= '0;
      end else begin
         ff1_q <= i_pin;
         ff2_q <= ff1_q;
         ff3_q <= ff2_q;
         lvl_q <= (ff2_q ~^ ff3_q) & ff3_q | ~(ff2_q ~^ ff3_q) & lvl_q;
      end
   end

   assign o_level = lvl_q;
endmodule
`default_nettype wire

// >>> vms_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "vms_map.svh"
// serial control of a four-by-four video switch matrix
module vms_top (
   input  wire logic       i_sys_clk,
   input  wire logic       i_reset,
   input  wire logic       i_link_scl_clk,
   input  wire logic       i_scl_level,
   input  wire logic       i_sda_in,
   input  wire logic       i_strap_bit_low,
   input  wire logic       i_strap_bit_mid,
   input  wire logic       i_strap_bit_high,
   output logic            o_sda_out,
   output logic            o_sda_oe,
   output logic [7:0]      o_route,
   output logic [3:0]      o_gain_sel,
   output logic [1:0]      o_clamp_off,
   output logic            o_aux_logic_out_0,
   output logic            o_aux_logic_out_1,
   output logic [3:0]      o_drive_on,
   output logic            o_pin_mode
);

   // ---------------- system clock side ----------------

   logic [4:0] pins_s;
   logic [2:0] strap_s;
   logic       scl_s;
   logic       sda_s;

   // straps and both bus lines pass three flops
   vms_sync #(
      .WIDTH (5)
   ) u_sync (
      .i_clk   (i_sys_clk),
      .i_reset (i_reset),
      .i_pin   ({i_strap_bit_high, i_strap_bit_mid, i_strap_bit_low,
                 i_scl_level, i_sda_in}),
      .o_level (pins_s)
   );

   assign strap_s = pins_s[4:2];
   assign scl_s   = pins_s[1];
   assign sda_s   = pins_s[0];

   logic [2:0] strap_q;
   logic       pin_mode_q;
   logic       scl_prev_q;
   logic       sda_prev_q;
   logic       clr_q;
   logic       clr_d;

   // start and stop seen on the synchronised lines
   wire start_det = scl_s & scl_prev_q & sda_prev_q & ~sda_s;
   wire stop_det  = scl_s & scl_prev_q & ~sda_prev_q & sda_s;

   // frame clear holds until SCL is low, when no link edge can come
   assign clr_d = (start_det | stop_det) ? 1'b1 :
                  (scl_s ? clr_q : 1'b0);

   // strap capture and frame boundary tracking
   always_ff @(posedge i_sys_clk or posedge i_reset) begin
      if (i_reset) begin
         strap_q    <= 3'h0;
         pin_mode_q <= 1'b0;
         scl_prev_q <= 1'b0;
         sda_prev_q <= 1'b0;
         clr_q      <= 1'b1;
      end else begin
         strap_q    <= strap_s;
         pin_mode_q <= &strap_s;
         scl_prev_q <= scl_s;
         sda_prev_q <= sda_s;
         clr_q      <= clr_d;
      end
   end

   // link logic is cleared by reset or by each start and stop
   wire link_rst = i_reset | clr_q;

   // ---------------- link clock side ----------------

   logic [3:0]               bit_cnt_q;
   logic [7:0]               shift_q;
   vms_pkg::vms_phase_e      phase_q;
   vms_pkg::vms_idx_t        ptr_q;
   vms_pkg::vms_idx_t        ptr_next;
   logic                     sda_oe_q;

   wire ack_slot = (bit_cnt_q == `VMS_ACK_SLOT);

   // address byte: fixed nibble, strap bits, write direction
   wire addr_hit = (shift_q == {`VMS_ADDR_FIXED, strap_q, 1'b0}) &
                   ~pin_mode_q;

   // select byte must pad with zeros and name one of three registers
   wire sub_ok = (shift_q[7:2] == 6'h00) &
                 (shift_q[1:0] != 2'h3);

   // acknowledge wanted for the byte just shifted in
   wire ack_want = ((phase_q == vms_pkg::PH_ADDR) & addr_hit) |
                   ((phase_q == vms_pkg::PH_SUB) & sub_ok) |
                   (phase_q == vms_pkg::PH_DATA);

   // a data byte is stored at its acknowledge clock, never earlier
   wire commit = ack_slot & sda_oe_q &
                 (phase_q == vms_pkg::PH_DATA);

   // pointer steps through three registers and wraps
   assign ptr_next = (ptr_q == `VMS_OFS_OE) ? `VMS_OFS_ROUTE :
                     vms_pkg::vms_idx_t'(ptr_q + 2'h1);

   // bit counting, shifting and phase steps on rising SCL
   always_ff @(posedge i_link_scl_clk or posedge link_rst) begin
      if (link_rst) begin
         bit_cnt_q <= 4'h0;
         shift_q   <= 8'h00;
         phase_q   <= vms_pkg::PH_ADDR;
         ptr_q     <= `VMS_OFS_ROUTE;
      end else if (!ack_slot) begin
         bit_cnt_q <= bit_cnt_q + 4'h1;
         shift_q   <= {shift_q[6:0], i_sda_in};
      end else begin
         bit_cnt_q <= 4'h0;
         if (!sda_oe_q) begin
            phase_q <= vms_pkg::PH_IGNORE; // rest of frame is not ours
         end else begin
            unique case (phase_q)
               vms_pkg::PH_ADDR: begin
                  phase_q <= vms_pkg::PH_SUB;
               end
               vms_pkg::PH_SUB: begin
                  phase_q <= vms_pkg::PH_DATA;
                  ptr_q   <= shift_q[1:0];
               end
               vms_pkg::PH_DATA: begin
                  ptr_q <= ptr_next;
               end
               vms_pkg::PH_IGNORE: begin
                  phase_q <= vms_pkg::PH_IGNORE;
               end
            endcase
         end
      end
   end

   // acknowledge driven on falling SCL, held through the ninth clock
   always_ff @(negedge i_link_scl_clk or posedge link_rst) begin
      if (link_rst) begin
         sda_oe_q <= 1'b0;
      end else begin
         sda_oe_q <= ack_slot & ack_want;
      end
   end

   // open-drain data line: only ever pulled low
   assign o_sda_out = 1'b0;
   assign o_sda_oe  = sda_oe_q;

   // ---------------- crossing of committed bytes ----------------

   logic       cdc_valid;
   logic [9:0] cdc_word;

   // the source side keeps its toggle across frame clears
   vms_word_cdc #(
      .WIDTH (10)
   ) u_cdc (
      .i_src_clk   (i_link_scl_clk),
      .i_src_reset (i_reset),
      .i_send      (commit),
      .i_word      ({ptr_q, shift_q}),
      .i_dst_clk   (i_sys_clk),
      .i_dst_reset (i_reset),
      .o_valid     (cdc_valid),
      .o_word      (cdc_word)
   );

   wire [1:0] wr_idx  = cdc_word[9:8];
   wire [7:0] wr_data = cdc_word[7:0];
   wire wr_route = cdc_valid & (wr_idx == `VMS_OFS_ROUTE);
   wire wr_gca   = cdc_valid & (wr_idx == `VMS_OFS_GCA);
   wire wr_oe    = cdc_valid & (wr_idx == `VMS_OFS_OE);

   // ---------------- control registers ----------------

   logic [7:0] route_q;
   logic [7:0] gca_q;
   logic [7:0] oe_q;

   // power-on values: source 0, gain two, clamps on, all off
   always_ff @(posedge i_sys_clk or posedge i_reset) begin
      if (i_reset) begin
         route_q <= `VMS_RST_ROUTE;
         gca_q   <= `VMS_RST_GCA;
         oe_q    <= `VMS_RST_OE;
      end else begin
         if (wr_route) begin
            route_q <= wr_data;
         end
         if (wr_gca) begin
            gca_q <= wr_data;
         end
         if (wr_oe) begin
            oe_q <= wr_data;
         end
      end
   end

   // ---------------- output selection ----------------

   // pin mode: output j takes source j xor {SCL, SDA}
   logic [7:0] pin_route;
   genvar gj;
   generate
      for (gj = 0; gj < 4; gj++) begin : g_pin_route
         assign pin_route[2*gj+1:2*gj] = 2'(gj) ^ {scl_s, sda_s};
      end
   endgenerate

   // bus mode uses the registers; pin mode fixes gain, clamp, drive
   wire [7:0] sel_route = pin_mode_q ? pin_route : route_q;
   wire [3:0] sel_gain  = pin_mode_q ? 4'h0 :
                          gca_q[`VMS_GAIN_MSB:`VMS_GAIN_LSB];
   wire [1:0] sel_clamp = pin_mode_q ? 2'h0 :
                          gca_q[`VMS_CLAMP_MSB:`VMS_CLAMP_LSB];
   wire [3:0] sel_drive = pin_mode_q ? `VMS_PIN_DRIVE :
                          oe_q[`VMS_EN_MSB:0];

   logic [7:0] out_route_q;
   logic [3:0] out_gain_q;
   logic [1:0] out_clamp_q;
   logic [1:0] out_aux_q;
   logic [3:0] out_drive_q;

   // outputs come from flops; upper enable bits never reach them
   always_ff @(posedge i_sys_clk or posedge i_reset) begin
      if (i_reset) begin
         out_route_q <= 8'h00;
         out_gain_q  <= 4'h0;
         out_clamp_q <= 2'h0;
         out_aux_q   <= 2'h0;
         out_drive_q <= 4'h0;
      end else begin
         out_route_q <= sel_route;
         out_gain_q  <= sel_gain;
         out_clamp_q <= sel_clamp;
         out_aux_q   <= {gca_q[`VMS_AUX1_BIT], gca_q[`VMS_AUX0_BIT]};
         out_drive_q <= sel_drive;
      end
   end

   assign o_route           = out_route_q;
   assign o_gain_sel        = out_gain_q;
   assign o_clamp_off       = out_clamp_q;
   assign o_aux_logic_out_0 = out_aux_q[0];
   assign o_aux_logic_out_1 = out_aux_q[1];
   assign o_drive_on        = out_drive_q;
   assign o_pin_mode        = pin_mode_q;

   // ---------------- assertions ----------------

   // read direction is never acknowledged
   property p_addr_read_nak;
      @(posedge i_link_scl_clk) disable iff (link_rst)
      (ack_slot && phase_q == vms_pkg::PH_ADDR && shift_q[0]) |-> !sda_oe_q;
   endproperty
   a_addr_read_nak: assert property (p_addr_read_nak)
      else $error("read address acknowledged");

   // a strap mismatch gets no acknowledge
   property p_strap_nak;
      @(posedge i_link_scl_clk) disable iff (link_rst)
      (ack_slot && phase_q == vms_pkg::PH_ADDR && shift_q[3:1] != strap_q)
      |-> !sda_oe_q;
   endproperty
   a_strap_nak: assert property (p_strap_nak)
      else $error("foreign address acknowledged");

   // pin mode leaves the bus alone
   property p_pin_nak;
      @(posedge i_link_scl_clk) disable iff (link_rst)
      (ack_slot && phase_q == vms_pkg::PH_ADDR && pin_mode_q) |-> !sda_oe_q;
   endproperty
   a_pin_nak: assert property (p_pin_nak)
      else $error("acknowledge in pin mode");

   // every data byte is acknowledged
   property p_data_ack;
      @(posedge i_link_scl_clk) disable iff (link_rst)
      (ack_slot && phase_q == vms_pkg::PH_DATA) |-> sda_oe_q;
   endproperty
   a_data_ack: assert property (p_data_ack)
      else $error("data byte not acknowledged");

   // select byte with nonzero bits 7:2 is refused
   property p_sub_nak;
      @(posedge i_link_scl_clk) disable iff (link_rst)
      (ack_slot && phase_q == vms_pkg::PH_SUB && shift_q[7:2] != 6'h00)
      |-> !sda_oe_q;
   endproperty
   a_sub_nak: assert property (p_sub_nak)
      else $error("bad select byte acknowledged");

   // pointer steps by one below the last register
   property p_ptr_step;
      @(posedge i_link_scl_clk) disable iff (link_rst)
      (commit && ptr_q != `VMS_OFS_OE) |=> ptr_q == $past(ptr_q) + 2'h1;
   endproperty
   a_ptr_step: assert property (p_ptr_step)
      else $error("pointer did not advance");

   // pointer wraps after the last register
   property p_ptr_wrap;
      @(posedge i_link_scl_clk) disable iff (link_rst)
      (commit && ptr_q == `VMS_OFS_OE) |=> ptr_q == `VMS_OFS_ROUTE;
   endproperty
   a_ptr_wrap: assert property (p_ptr_wrap)
      else $error("pointer did not wrap");

   // a crossed routing byte lands in the register
   property p_route_store;
      @(posedge i_sys_clk) disable iff (i_reset)
      wr_route |=> route_q == $past(wr_data);
   endproperty
   a_route_store: assert property (p_route_store)
      else $error("routing byte not stored");

   // gain and enable registers hold without a crossed byte
   property p_no_stray;
      @(posedge i_sys_clk) disable iff (i_reset)
      !cdc_valid |=> $stable(gca_q) && $stable(oe_q);
   endproperty
   a_no_stray: assert property (p_no_stray)
      else $error("register changed without a byte");

   // two bus-mode cycles: enables and logic output 0 follow the registers
   sequence s_bus_mode;
      !pin_mode_q ##1 !pin_mode_q;
   endsequence
   property p_drive_follow;
      @(posedge i_sys_clk) disable iff (i_reset)
      s_bus_mode |-> o_drive_on == $past(oe_q[3:0]) &&
                     o_aux_logic_out_0 == $past(gca_q[0]);
   endproperty
   a_drive_follow: assert property (p_drive_follow)
      else $error("outputs do not follow registers");

   // pin mode drives every output
   property p_pin_drive;
      @(posedge i_sys_clk) disable iff (i_reset)
      pin_mode_q |=> o_drive_on == `VMS_PIN_DRIVE;
   endproperty
   a_pin_drive: assert property (p_pin_drive)
      else $error("pin mode output not active");

endmodule
`default_nettype wire

// >>> vms_word_cdc.sv
`timescale 1ns/1ps
`default_nettype none
// toggle crossing for one word; source holds it until the next send
module vms_word_cdc #(
   parameter int WIDTH = 10
) (
   input  wire logic             i_src_clk,
   input  wire logic             i_src_reset,
   input  wire logic             i_send,
   input  wire logic [WIDTH-1:0] i_word,
   input  wire logic             i_dst_clk,
   input  wire logic             i_dst_reset,
   output logic                  o_valid,
   output logic      [WIDTH-1:0] o_word
);
   logic             tog_q;
   logic [WIDTH-1:0] hold_q;
   logic             tsync1_q;
   logic             tsync2_q;
   logic             tsync3_q;
   logic             valid_q;
   logic [WIDTH-1:0] word_q;
   wire              arrive = tsync2_q ^ tsync3_q;

   // source side: the word stays put for many link clocks
   always_ff @(posedge i_src_clk or posedge i_src_reset) begin
      if (i_src_reset) begin
         tog_q  <= 1'b0;
         hold_q <= '0;
      end else if (i_send) begin
         tog_q  <= ~tog_q;
         hold_q <= i_word;
      end
   end

   // destination side: the first toggle flop is read by the second alone
   always_ff @(posedge i_dst_clk or posedge i_dst_reset) begin
      if (i_dst_reset) begin
         tsync1_q <= 1'b0;
         tsync2_q <= 1'b0;
         tsync3_q <= 1'b0;
         valid_q  <= 1'b0;
         word_q   <= '0;
      end else begin
         tsync1_q <= tog_q;
         tsync2_q <= tsync1_q;
         tsync3_q <= tsync2_q;
         valid_q <= arrive;
         if (arrive) begin
            word_q <= hold_q;
         end
      end
   end

   assign o_valid = valid_q;
   assign o_word  = word_q;
endmodule
`default_nettype wire
